// ### hw/jmc_pkg.sv
package jmc_pkg;

  typedef struct packed {
    logic ok;
    logic des;
    logic [4:0] dec;
    logic [1:0] links;
    logic [4:0] n;
    logic [4:0] np;
    logic [3:0] l;
    logic [3:0] m;
    logic [3:0] f;
    logic [3:0] s;
    logic [4:0] r4;
    logic [5:0] kmin;
    logic [1:0] kstep;
  } jmc_mode_s;

  // ---------------------------------------------------------------
  // Mode table, indexed by link_mode_select; r4 is R times four.
  // ---------------------------------------------------------------
  localparam logic [4:0] JMC_MODE_CNT = 5'h13;
  localparam jmc_mode_s JMC_MODE_TAB [19] = '{
    '{1'h1, 1'h1, 5'h01, 2'h2, 5'h0c, 5'h0c, 4'h4, 4'h4, 4'h8, 4'h5, 5'h10, 6'h03, 2'h1},
    '{1'h1, 1'h1, 5'h01, 2'h2, 5'h0c, 5'h0c, 4'h8, 4'h8, 4'h8, 4'h5, 5'h08, 6'h03, 2'h1},
    '{1'h1, 1'h0, 5'h01, 2'h2, 5'h0c, 5'h0c, 4'h4, 4'h4, 4'h8, 4'h5, 5'h10, 6'h03, 2'h1},
    '{1'h1, 1'h0, 5'h01, 2'h2, 5'h0c, 5'h0c, 4'h8, 4'h8, 4'h8, 4'h5, 5'h08, 6'h03, 2'h1},
    '{1'h1, 1'h1, 5'h01, 2'h2, 5'h08, 5'h08, 4'h2, 4'h1, 4'h1, 4'h2, 5'h14, 6'h12, 2'h2},
    '{1'h1, 1'h1, 5'h01, 2'h2, 5'h08, 5'h08, 4'h4, 4'h1, 4'h1, 4'h4, 5'h0a, 6'h12, 2'h2},
    '{1'h1, 1'h0, 5'h01, 2'h2, 5'h08, 5'h08, 4'h2, 4'h1, 4'h1, 4'h2, 5'h14, 6'h12, 2'h2},
    '{1'h1, 1'h0, 5'h01, 2'h2, 5'h08, 5'h08, 4'h4, 4'h1, 4'h1, 4'h4, 5'h0a, 6'h12, 2'h2},
    '{1'h0, 1'h0, 5'h00, 2'h0, 5'h00, 5'h00, 4'h0, 4'h0, 4'h0, 4'h0, 5'h00, 6'h00, 2'h0},
    '{1'h1, 1'h0, 5'h02, 2'h2, 5'h0f, 5'h10, 4'h4, 4'h1, 4'h2, 4'h4, 5'h0a, 6'h09, 2'h1},
    '{1'h1, 1'h0, 5'h04, 2'h2, 5'h0f, 5'h10, 4'h2, 4'h2, 4'h2, 4'h1, 5'h14, 6'h09, 2'h1},
    '{1'h1, 1'h0, 5'h04, 2'h2, 5'h0f, 5'h10, 4'h4, 4'h2, 4'h2, 4'h2, 5'h0a, 6'h09, 2'h1},
    '{1'h1, 1'h0, 5'h04, 2'h2, 5'h0c, 5'h0c, 4'h8, 4'h8, 4'h8, 4'h5, 5'h04, 6'h03, 2'h1},
    '{1'h1, 1'h0, 5'h08, 2'h2, 5'h0f, 5'h10, 4'h1, 4'h2, 4'h4, 4'h1, 5'h14, 6'h05, 2'h1},
    '{1'h1, 1'h0, 5'h08, 2'h2, 5'h0f, 5'h10, 4'h2, 4'h2, 4'h2, 4'h1, 5'h0a, 6'h09, 2'h1},
    '{1'h1, 1'h0, 5'h10, 2'h1, 5'h0f, 5'h10, 4'h1, 4'h4, 4'h8, 4'h1, 5'h14, 6'h03, 2'h1},
    '{1'h1, 1'h0, 5'h10, 2'h2, 5'h0f, 5'h10, 4'h1, 4'h2, 4'h4, 4'h1, 5'h0a, 6'h05, 2'h1},
    '{1'h1, 1'h1, 5'h01, 2'h2, 5'h08, 5'h08, 4'h8, 4'h1, 4'h1, 4'h8, 5'h05, 6'h12, 2'h2},
    '{1'h1, 1'h0, 5'h01, 2'h2, 5'h08, 5'h08, 4'h8, 4'h1, 4'h1, 4'h8, 5'h05, 6'h12, 2'h2}
  };

  // ---------------------------------------------------------------
  // Constants.
  // ---------------------------------------------------------------
  localparam logic [4:0] JMC_R4_BYPASS = 5'h04;
  localparam logic [2:0] JMC_JESDV = 3'h1;
  localparam logic [2:0] JMC_SUBCLASSV = 3'h1;
  localparam logic [3:0] JMC_IDX_LAST = 4'hd;
  localparam logic [3:0] JMC_IDX_CHK = 4'hd;
  localparam logic [2:0] JMC_DREG_MODE = 3'h0;
  localparam logic [2:0] JMC_DREG_KM1 = 3'h1;
  localparam logic [2:0] JMC_DREG_DID = 3'h2;
  localparam logic [2:0] JMC_DREG_CTRL = 3'h3;
  localparam int JMC_CTRL_EN = 0;
  localparam int JMC_CTRL_SCR = 1;
  localparam int JMC_CTRL_INB = 2;
  localparam logic [4:0] JMC_MODE_RST = 5'h00;
  localparam logic [4:0] JMC_KM1_RST = 5'h1f;
  localparam logic [7:0] JMC_DID_RST = 8'h00;
  localparam logic [11:0] JMC_A_CTRL = 12'h000;
  localparam logic [11:0] JMC_A_MODE = 12'h004;
  localparam logic [11:0] JMC_A_KM1 = 12'h008;
  localparam logic [11:0] JMC_A_DID = 12'h00c;
  localparam logic [11:0] JMC_A_STAT = 12'h010;
  localparam logic [11:0] JMC_A_INFO = 12'h014;
  localparam int JMC_ST_UP = 0;
  localparam int JMC_ST_CHK = 1;
  localparam int JMC_ST_CFG = 2;
  localparam int JMC_ST_DID = 3;

  // ---------------------------------------------------------------
  // Shared functions.
  // ---------------------------------------------------------------
  function automatic jmc_mode_s jmc_entry(input logic [4:0] mode);
    jmc_entry = (mode < JMC_MODE_CNT) ? JMC_MODE_TAB[mode] : '0;
  endfunction

  function automatic logic jmc_k_ok(input jmc_mode_s e, input logic [4:0] km1);
    logic [5:0] k;
    logic [5:0] diff;
    k = {1'b0, km1} + 6'h01;
    diff = k - e.kmin;
    jmc_k_ok = e.ok && (k >= e.kmin) && ((e.kstep == 2'h1) || !diff[0]);
  endfunction

  function automatic logic [7:0] jmc_build_octet(input jmc_mode_s e, input logic [7:0] did,
      input logic [2:0] lid, input logic scr, input logic [4:0] km1, input logic [3:0] idx);
    case (idx)
      4'h0: jmc_build_octet = did;
      4'h2: jmc_build_octet = {5'h00, lid};
      4'h3: jmc_build_octet = {scr, 2'h0, 5'({1'b0, e.l} - 5'h01)};
      4'h4: jmc_build_octet = {4'h0, e.f} - 8'h01;
      4'h5: jmc_build_octet = {3'h0, km1};
      4'h6: jmc_build_octet = {4'h0, e.m} - 8'h01;
      4'h7: jmc_build_octet = {3'h0, e.n - 5'h01};
      4'h8: jmc_build_octet = {JMC_SUBCLASSV, e.np - 5'h01};
      4'h9: jmc_build_octet = {JMC_JESDV, 5'({1'b0, e.s} - 5'h01)};
      default: jmc_build_octet = 8'h00;
    endcase
  endfunction

  // Sum of the separate fields packed in one octet.
  function automatic logic [7:0] jmc_field_sum(input logic [3:0] idx, input logic [7:0] o);
    case (idx)
      4'h1: jmc_field_sum = {4'h0, o[7:4]} + {4'h0, o[3:0]};
      4'h2: jmc_field_sum = {7'h00, o[6]} + {7'h00, o[5]} + {3'h0, o[4:0]};
      4'h3, 4'ha: jmc_field_sum = {7'h00, o[7]} + {3'h0, o[4:0]};
      4'h5: jmc_field_sum = {3'h0, o[4:0]};
      4'h7: jmc_field_sum = {6'h00, o[7:6]} + {3'h0, o[4:0]};
      4'h8, 4'h9: jmc_field_sum = {5'h00, o[7:5]} + {3'h0, o[4:0]};
      default: jmc_field_sum = o;
    endcase
  endfunction

endpackage

// ### hw/jmc_link_if.sv
`timescale 1ns/1ps
interface jmc_link_if;
  logic cfg_we;
  logic [2:0] cfg_addr;
  logic [7:0] cfg_wdata;
  logic ilas_valid;
  logic ilas_link;
  logic [2:0] ilas_lane;
  logic [3:0] ilas_idx;
  logic [7:0] ilas_octet;
  logic cfg_err;
  logic link_up;
  modport dev (
    input cfg_we,
    input cfg_addr,
    input cfg_wdata,
    output ilas_valid,
    output ilas_link,
    output ilas_lane,
    output ilas_idx,
    output ilas_octet,
    output cfg_err,
    output link_up
  );
  modport rx (
    output cfg_we,
    output cfg_addr,
    output cfg_wdata,
    input ilas_valid,
    input ilas_link,
    input ilas_lane,
    input ilas_idx,
    input ilas_octet,
    input cfg_err,
    input link_up
  );
endinterface

// ### hw/jmc_ilas_octet.sv
`timescale 1ns/1ps
module jmc_ilas_octet (
  input jmc_pkg::jmc_mode_s ent,
  input wire logic [7:0] did,
  input wire logic [2:0] lid,
  input wire logic scr,
  input wire logic [4:0] km1,
  input wire logic [3:0] idx,
  output logic [7:0] octet
);
  import jmc_pkg::*;

  logic [7:0] chk;

  always_comb begin
    chk = 8'h00;
    for (int i = 0; i < 13; i++) begin
      chk = chk + jmc_field_sum(4'(i), jmc_build_octet(ent, did, lid, scr, km1, 4'(i)));
    end
  end

  always_comb begin
    if (idx == JMC_IDX_CHK) begin
      octet = chk;
    end else begin
      octet = jmc_build_octet(ent, did, lid, scr, km1, idx);
    end
  end
endmodule

// ### hw/jmc_dev_end.sv
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module jmc_dev_end (
  input wire logic pclk,
  input wire logic presetn,
  jmc_link_if.dev link,
  output logic des_q,
  output logic fs_double_q,
  output logic ddc_avail_q,
  output logic input_b_sel_q,
  output logic dual_inputs_q,
  output logic [4:0] decim_q,
  output logic [4:0] serdes_mult_x4_q,
  output logic pll_bypass_q,
  output logic scramble_en_q,
  output logic [3:0] conv_count_q,
  output logic [15:0] lane_pwr_en_q
);
  import jmc_pkg::*;

  typedef enum logic [1:0] {
    JMC_IDLE = 2'b00,
    JMC_SEND = 2'b01,
    JMC_UP = 2'b10
  } jmc_state_e;

  logic [4:0] mode_q;
  logic [4:0] km1_q;
  logic [7:0] did_q;
  logic en_q;
  logic scr_q;
  logic inb_q;
  jmc_mode_s ent;
  logic cfg_ok;
  jmc_state_e state_q;
  jmc_mode_s lat_q;
  logic [4:0] lat_km1_q;
  logic [7:0] lat_did_q;
  logic lat_scr_q;
  logic [3:0] idx_q;
  logic [2:0] lane_q;
  logic lnk_q;
  logic [7:0] did_eff;
  logic [7:0] octet;
  logic last_lane;
  logic last_link;

  // ---------------------------------------------------------------
  // Configuration registers.
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= JMC_MODE_RST;
      km1_q <= JMC_KM1_RST;
      did_q <= JMC_DID_RST;
      en_q <= 1'b0;
      scr_q <= 1'b0;
      inb_q <= 1'b0;
    end else if (link.cfg_we) begin
      case (link.cfg_addr)
        JMC_DREG_MODE: mode_q <= link.cfg_wdata[4:0];
        JMC_DREG_KM1: km1_q <= link.cfg_wdata[4:0];
        JMC_DREG_DID: did_q <= link.cfg_wdata;
        JMC_DREG_CTRL: begin
          en_q <= link.cfg_wdata[JMC_CTRL_EN];
          scr_q <= link.cfg_wdata[JMC_CTRL_SCR];
          inb_q <= link.cfg_wdata[JMC_CTRL_INB];
        end
        default: ;
      endcase
    end
  end

  assign ent = jmc_entry(mode_q);
  assign cfg_ok = jmc_k_ok(ent, km1_q);

  // ---------------------------------------------------------------
  // Derived converter and serializer controls.
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      des_q <= 1'b0;
      fs_double_q <= 1'b0;
      ddc_avail_q <= 1'b0;
      input_b_sel_q <= 1'b0;
      dual_inputs_q <= 1'b0;
      decim_q <= 5'h00;
      serdes_mult_x4_q <= 5'h00;
      pll_bypass_q <= 1'b0;
      scramble_en_q <= 1'b0;
      conv_count_q <= 4'h0;
    end else begin
      des_q <= ent.des;
      fs_double_q <= ent.ok & ent.des;
      ddc_avail_q <= ent.ok & ~ent.des;
      input_b_sel_q <= ent.des & inb_q;
      dual_inputs_q <= ent.ok & ~ent.des;
      decim_q <= ent.dec;
      serdes_mult_x4_q <= ent.r4;
      pll_bypass_q <= ent.ok && (ent.r4 == JMC_R4_BYPASS);
      scramble_en_q <= scr_q;
      conv_count_q <= ent.m;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane_pwr_en_q <= 16'h0000;
    end else begin
      for (int i = 0; i < 8; i++) begin
        lane_pwr_en_q[i] <= ent.ok && (4'(i) < ent.l);
        lane_pwr_en_q[i + 8] <= ent.ok && (4'(i) < ent.l) && (ent.links == 2'h2);
      end
    end
  end

  // ---------------------------------------------------------------
  // Alignment sequence parameter stream.
  // ---------------------------------------------------------------
  // A configuration change while the link runs reaches the parameter stream only at
  // the next enable, so one sequence never mixes two parameter sets.
  assign last_lane = ({1'b0, lane_q} == lat_q.l - 4'h1);
  assign last_link = ({1'b0, lnk_q} == lat_q.links - 2'h1);
  assign did_eff = lat_did_q + {7'h00, lnk_q};

  jmc_ilas_octet u_octet (
    .ent(lat_q),
    .did(did_eff),
    .lid(lane_q),
    .scr(lat_scr_q),
    .km1(lat_km1_q),
    .idx(idx_q),
    .octet(octet)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= JMC_IDLE;
      lat_q <= '0;
      lat_km1_q <= 5'h00;
      lat_did_q <= 8'h00;
      lat_scr_q <= 1'b0;
      idx_q <= 4'h0;
      lane_q <= 3'h0;
      lnk_q <= 1'b0;
    end else begin
      case (state_q)
        JMC_IDLE: begin
          idx_q <= 4'h0;
          lane_q <= 3'h0;
          lnk_q <= 1'b0;
          if (en_q && cfg_ok) begin
            lat_q <= ent;
            lat_km1_q <= km1_q;
            lat_did_q <= did_q;
            lat_scr_q <= scr_q;
            state_q <= JMC_SEND;
          end
        end
        JMC_SEND: begin
          if (!en_q) begin
            state_q <= JMC_IDLE;
          end else if (idx_q != JMC_IDX_LAST) begin
            idx_q <= idx_q + 4'h1;
          end else begin
            idx_q <= 4'h0;
            if (!last_lane) begin
              lane_q <= lane_q + 3'h1;
            end else begin
              lane_q <= 3'h0;
              if (!last_link) begin
                lnk_q <= 1'b1;
              end else begin
                state_q <= JMC_UP;
              end
            end
          end
        end
        JMC_UP: begin
          if (!en_q) begin
            state_q <= JMC_IDLE;
          end
        end
        default: state_q <= JMC_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.ilas_valid <= 1'b0;
      link.ilas_link <= 1'b0;
      link.ilas_lane <= 3'h0;
      link.ilas_idx <= 4'h0;
      link.ilas_octet <= 8'h00;
      link.cfg_err <= 1'b0;
      link.link_up <= 1'b0;
    end else begin
      link.ilas_valid <= (state_q == JMC_SEND) && en_q;
      link.ilas_link <= lnk_q;
      link.ilas_lane <= lane_q;
      link.ilas_idx <= idx_q;
      link.ilas_octet <= octet;
      link.cfg_err <= en_q && !cfg_ok && (state_q == JMC_IDLE);
      link.link_up <= (state_q == JMC_UP) && en_q;
    end
  end
endmodule

// ### hw/jmc_host_end.sv
`timescale 1ns/1ps
module jmc_host_end (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  jmc_link_if.rx link
);
  import jmc_pkg::*;

  logic [2:0] ctrl_q;
  logic [4:0] mode_q;
  logic [4:0] km1_q;
  logic [7:0] did_q;
  logic chk_err_q;
  logic did_err_q;
  logic [7:0] acc_q;
  logic [31:0] info_q;
  logic refuse;
  logic mapped;
  logic setup;
  logic wr;

  // ---------------------------------------------------------------
  // APB slave: one wait-free access cycle after setup.
  // ---------------------------------------------------------------
  assign setup = psel && !penable;
  assign wr = psel && penable && pready && pwrite && !pslverr;
  assign mapped = (paddr <= JMC_A_INFO) && (paddr[1:0] == 2'h0);

  // Defined modes only. K within range.
  always_comb begin
    refuse = 1'b0;
    if (pwrite && paddr == JMC_A_MODE) begin
      refuse = !jmc_k_ok(jmc_entry(pwdata[4:0]), km1_q);
    end else if (pwrite && paddr == JMC_A_KM1) begin
      refuse = !jmc_k_ok(jmc_entry(mode_q), pwdata[4:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup && (!mapped || refuse);
      if (setup) begin
        case (paddr)
          JMC_A_CTRL: prdata <= {29'h0, ctrl_q};
          JMC_A_MODE: prdata <= {27'h0, mode_q};
          JMC_A_KM1: prdata <= {27'h0, km1_q};
          JMC_A_DID: prdata <= {24'h0, did_q};
          JMC_A_STAT: prdata <= {28'h0, did_err_q, link.cfg_err, chk_err_q, link.link_up};
          JMC_A_INFO: prdata <= info_q;
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Local copies, forwarded to the device one cycle later.
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 3'h0;
      mode_q <= JMC_MODE_RST;
      km1_q <= JMC_KM1_RST;
      did_q <= JMC_DID_RST;
      link.cfg_we <= 1'b0;
      link.cfg_addr <= 3'h0;
      link.cfg_wdata <= 8'h00;
    end else begin
      link.cfg_we <= wr && (paddr <= JMC_A_DID);
      link.cfg_wdata <= pwdata[7:0];
      if (wr) begin
        case (paddr)
          JMC_A_CTRL: begin
            ctrl_q <= pwdata[2:0];
            link.cfg_addr <= JMC_DREG_CTRL;
          end
          JMC_A_MODE: begin
            mode_q <= pwdata[4:0];
            link.cfg_addr <= JMC_DREG_MODE;
          end
          JMC_A_KM1: begin
            km1_q <= pwdata[4:0];
            link.cfg_addr <= JMC_DREG_KM1;
          end
          JMC_A_DID: begin
            did_q <= pwdata[7:0];
            link.cfg_addr <= JMC_DREG_DID;
          end
          default: ;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Receive check of the parameter stream; errors clear by writing one.
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= 8'h00;
      chk_err_q <= 1'b0;
      did_err_q <= 1'b0;
      info_q <= 32'h00000000;
    end else begin
      if (wr && paddr == JMC_A_STAT && pwdata[JMC_ST_CHK]) begin
        chk_err_q <= 1'b0;
      end
      if (wr && paddr == JMC_A_STAT && pwdata[JMC_ST_DID]) begin
        did_err_q <= 1'b0;
      end
      if (link.ilas_valid) begin
        if (link.ilas_idx == 4'h0) begin
          acc_q <= link.ilas_octet;
          if (link.ilas_octet != did_q + {7'h00, link.ilas_link}) begin
            did_err_q <= 1'b1;
          end
        end else if (link.ilas_idx != JMC_IDX_CHK) begin
          acc_q <= acc_q + jmc_field_sum(link.ilas_idx, link.ilas_octet);
        end else if (acc_q != link.ilas_octet) begin
          chk_err_q <= 1'b1;
        end
        if (!link.ilas_link && link.ilas_lane == 3'h0) begin
          case (link.ilas_idx)
            4'h3: info_q[7:0] <= link.ilas_octet;
            4'h4: info_q[15:8] <= link.ilas_octet;
            4'h6: info_q[23:16] <= link.ilas_octet;
            4'h9: info_q[31:24] <= link.ilas_octet;
            default: ;
          endcase
        end
      end
    end
  end
endmodule

// ### testbench/jmc_link_props.sv
`timescale 1ns/1ps
module jmc_link_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cfg_we,
  input wire logic [2:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic ilas_valid,
  input wire logic ilas_link,
  input wire logic [2:0] ilas_lane,
  input wire logic [3:0] ilas_idx,
  input wire logic [7:0] ilas_octet,
  input wire logic cfg_err,
  input wire logic link_up
);
  import jmc_pkg::*;
  logic [7:0] did_q;
  logic scr_q;
  logic [7:0] sum_q;

  // Field sum of one octet; unused bits are left out of the sum.
  function automatic logic [7:0] fsum(input logic [3:0] i, input logic [7:0] o);
    case (i)
      4'h1: fsum = {4'h0, o[7:4]} + {4'h0, o[3:0]};
      4'h2: fsum = {7'h00, o[6]} + {7'h00, o[5]} + {3'h0, o[4:0]};
      4'h3, 4'ha: fsum = {7'h00, o[7]} + {3'h0, o[4:0]};
      4'h5: fsum = {3'h0, o[4:0]};
      4'h7: fsum = {6'h00, o[7:6]} + {3'h0, o[4:0]};
      4'h8, 4'h9: fsum = {5'h00, o[7:5]} + {3'h0, o[4:0]};
      default: fsum = o;
    endcase
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      did_q <= JMC_DID_RST;
    end else if (cfg_we && cfg_addr == JMC_DREG_DID) begin
      did_q <= cfg_wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scr_q <= 1'b0;
    end else if (cfg_we && cfg_addr == JMC_DREG_CTRL) begin
      scr_q <= cfg_wdata[JMC_CTRL_SCR];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sum_q <= 8'h00;
    end else if (ilas_valid) begin
      sum_q <= (ilas_idx == 4'h0) ? fsum(ilas_idx, ilas_octet) : sum_q + fsum(ilas_idx, ilas_octet);
    end
  end

  // ---------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_next_octet;
    ilas_valid && ilas_idx == $past(ilas_idx) + 4'h1;
  endsequence

  a_octet_step: assert property (ilas_valid && ilas_idx != 4'hd |=> s_next_octet)
    else $error("octet index did not advance");
  a_lane_step: assert property (ilas_valid && ilas_idx == 4'hd |=> !ilas_valid ||
    (ilas_idx == 4'h0 && ((ilas_link == $past(ilas_link)) ? ilas_lane == $past(ilas_lane) + 3'h1
    : (ilas_lane == 3'h0 && ilas_link))))
    else $error("lane order broken");
  a_seq_start: assert property ($rose(ilas_valid) |-> ilas_idx == 4'h0 && ilas_lane == 3'h0 &&
    !ilas_link)
    else $error("sequence did not start at lane zero");
  a_zero_fields: assert property (ilas_valid && ilas_idx inside {4'h1, 4'ha, 4'hb, 4'hc} |->
    ilas_octet == 8'h00)
    else $error("fixed field not zero");
  a_lid_field: assert property (ilas_valid && ilas_idx == 4'h2 |-> ilas_octet == {5'h00, ilas_lane})
    else $error("lane id wrong");
  a_cs_zero: assert property (ilas_valid && ilas_idx == 4'h7 |-> ilas_octet[7:5] == 3'h0)
    else $error("control bits field not zero");
  a_ver_fields: assert property (ilas_valid && ilas_idx inside {4'h8, 4'h9} |->
    ilas_octet[7:5] == 3'h1)
    else $error("version field not one");
  a_scr_flag: assert property (ilas_valid && ilas_idx == 4'h3 |-> ilas_octet[7:5] == {scr_q, 2'h0})
    else $error("scrambler flag wrong");
  a_did_link: assert property (ilas_valid && ilas_idx == 4'h0 |->
    ilas_octet == did_q + {7'h00, ilas_link})
    else $error("device id wrong");
  a_chk_sum: assert property (ilas_valid && ilas_idx == 4'hd |-> ilas_octet == sum_q)
    else $error("checksum wrong");
endmodule

// ### testbench/jesd_mode_ilas_config_tb.sv
`timescale 1ns/1ps
module jesd_mode_ilas_config_tb;
  import jmc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, des_q, fs_double_q, ddc_avail_q, input_b_sel_q, dual_inputs_q;
  logic pll_bypass_q, scramble_en_q;
  logic [4:0] decim_q, serdes_mult_x4_q;
  logic [3:0] conv_count_q;
  logic [15:0] lane_pwr_en_q;
  int num_errors = 0;
  int compares = 0;
  int octets = 0;
  logic [31:0] rd;
  logic er;
  // Expected per mode: lanes, converters, decimation and R times four.
  int lt [19] = '{4, 8, 4, 8, 2, 4, 2, 4, 0, 4, 2, 4, 8, 1, 2, 1, 1, 8, 8};
  int mt [19] = '{4, 8, 4, 8, 1, 1, 1, 1, 0, 1, 2, 2, 8, 2, 2, 4, 2, 1, 1};
  int dt [19] = '{1, 1, 1, 1, 1, 1, 1, 1, 0, 2, 4, 4, 4, 8, 8, 16, 16, 1, 1};
  int rt [19] = '{16, 8, 16, 8, 20, 10, 20, 10, 0, 10, 20, 10, 4, 20, 10, 20, 10, 5, 5};
  logic [18:0] dm = 19'h20033;

  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    if (i_jmc_link_if.ilas_valid === 1'b1) octets++;
  end

  jmc_link_if i_jmc_link_if ();
  jmc_host_end i_jmc_host_end (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(i_jmc_link_if.rx));
  jmc_dev_end i_jmc_dev_end (.pclk(pclk), .presetn(presetn), .link(i_jmc_link_if.dev),
    .des_q(des_q), .fs_double_q(fs_double_q), .ddc_avail_q(ddc_avail_q),
    .input_b_sel_q(input_b_sel_q), .dual_inputs_q(dual_inputs_q), .decim_q(decim_q),
    .serdes_mult_x4_q(serdes_mult_x4_q), .pll_bypass_q(pll_bypass_q),
    .scramble_en_q(scramble_en_q), .conv_count_q(conv_count_q), .lane_pwr_en_q(lane_pwr_en_q));
  jmc_link_props i_jmc_link_props (.pclk(pclk), .presetn(presetn),
    .cfg_we(i_jmc_link_if.cfg_we), .cfg_addr(i_jmc_link_if.cfg_addr),
    .cfg_wdata(i_jmc_link_if.cfg_wdata), .ilas_valid(i_jmc_link_if.ilas_valid),
    .ilas_link(i_jmc_link_if.ilas_link), .ilas_lane(i_jmc_link_if.ilas_lane),
    .ilas_idx(i_jmc_link_if.ilas_idx), .ilas_octet(i_jmc_link_if.ilas_octet),
    .cfg_err(i_jmc_link_if.cfg_err), .link_up(i_jmc_link_if.link_up));

  // ---------------------------------------------------------------
  // Tasks.
  // ---------------------------------------------------------------
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // The slave's latency is not assumed; pready or the bound of 20 cycles ends the wait.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int n = 0; n < 20 && pready !== 1'b1; n++) @(posedge pclk);
    if (pready !== 1'b1) begin
      num_errors++;
      conclude();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic run_mode(input int m);
    logic [7:0] mask;
    logic [18:0] info;
    mask = 8'((16'h1 << lt[m]) - 16'h1);
    apb(1'b1, JMC_A_MODE, 32'(m));
    chk(32'(er), 32'(m == 8)); // Refusal.
    if (m == 8) begin
      apb(1'b0, JMC_A_MODE, 32'h0);
      chk(rd, 32'h7); // No effect.
      return;
    end
    repeat (4) @(posedge pclk);
    chk(32'(des_q), 32'(dm[m])); // Flag.
    chk(32'(fs_double_q), 32'(dm[m])); // Rate.
    chk(32'(dual_inputs_q), 32'(!dm[m])); // Both inputs.
    chk(32'(ddc_avail_q), 32'(!dm[m])); // Converters.
    chk(32'(decim_q), 32'(dt[m])); // Decimation.
    chk(32'(serdes_mult_x4_q), 32'(rt[m])); // Multiplier.
    chk(32'(pll_bypass_q), 32'(rt[m] == 4)); // Bypass.
    chk(32'(conv_count_q), 32'(mt[m])); // Count.
    chk(32'(lane_pwr_en_q), (m == 15) ? {24'h0, mask} : {16'h0, mask, mask}); // Lanes.
    octets = 0;
    apb(1'b1, JMC_A_CTRL, {29'h0, 1'(m >> 1), 1'(m), 1'b1});
    for (int n = 0; n < 600 && i_jmc_link_if.link_up !== 1'b1; n++) @(posedge pclk);
    chk(32'(i_jmc_link_if.link_up), 32'h1); // Up.
    if (i_jmc_link_if.link_up !== 1'b1) conclude();
    chk(32'(octets), 32'(14 * lt[m] * ((m == 15) ? 1 : 2))); // Octets.
    chk(32'(scramble_en_q), 32'(m % 2)); // Scrambler.
    chk(32'(input_b_sel_q), 32'(dm[m] && ((m >> 1) % 2))); // Input.
    apb(1'b0, JMC_A_STAT, 32'h0);
    chk(32'(rd[JMC_ST_UP]), 32'h1); // Status.
    chk(32'(rd[3:1]), 32'h0); // Checksum and identifier.
    apb(1'b0, JMC_A_INFO, 32'h0);
    info = {3'h1, 8'(mt[m] - 1), 1'(m % 2), 2'h0, 5'(lt[m] - 1)};
    chk(32'({rd[31:29], rd[23:16], rd[7:0]}), 32'(info)); // Parameters.
    apb(1'b1, JMC_A_CTRL, 32'h0);
  endtask

  // ---------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(32'(des_q), 32'h1); // Reset mode.
    chk(32'(lane_pwr_en_q), 32'h0f0f); // Reset lanes.
    apb(1'b0, JMC_A_MODE, 32'h0);
    chk(rd, 32'h0); // Reset mode.
    apb(1'b0, JMC_A_KM1, 32'h0);
    chk(rd, 32'h1f); // Reset value.
    apb(1'b0, 12'h018, 32'h0);
    chk(32'(er), 32'h1); // Unmapped.
    apb(1'b1, 12'h006, 32'h5);
    chk(32'(er), 32'h1); // Unaligned.
    apb(1'b1, JMC_A_DID, 32'h7f);
    chk(32'(er), 32'h0); // Identifier.
    apb(1'b1, JMC_A_MODE, 32'h4);
    apb(1'b1, JMC_A_KM1, 32'h10);
    chk(32'(er), 32'h1); // Below minimum.
    apb(1'b1, JMC_A_KM1, 32'h12);
    chk(32'(er), 32'h1); // Off step.
    apb(1'b1, JMC_A_KM1, 32'h11);
    chk(32'(er), 32'h0); // Minimum.
    for (int m = 0; m < 19; m++) run_mode(m);
    conclude();
  end
endmodule
